// >>> hdl/ssr_pkg.sv
package ssr_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DATA   = 8'h08;
  localparam logic [7:0] ADDR_BAUD   = 8'h0C;

  // Control register field positions.
  localparam int CTRL_SERIAL_PORT_ENABLE = 0;
  localparam int CTRL_CLOCK_SOURCE_SELECT = 1;
  localparam int CTRL_SINGLE_RECEIVE_ENABLE = 2;
  localparam int CTRL_CONTINUOUS_RECEIVE_ENABLE = 3;
  localparam int CTRL_RX9  = 4;
  localparam int CTRL_RECEIVE_IRQ_ENABLE = 5;

  // Status register field positions.
  localparam int STAT_PEND  = 0;
  localparam int STAT_OVR   = 1;
  localparam int STAT_NINTH = 2;
  localparam int STAT_CNT   = 4;

  // Sizes and reset values.
  localparam int               FIFO_DEPTH = 2;
  localparam logic [3:0]       BITS_8     = 4'h8;
  localparam logic [3:0]       BITS_9     = 4'h9;
  localparam logic [15:0]      BAUD_RESET = 16'h0004;
  localparam logic [1:0]       CNT_FULL   = 2'h2;

  typedef struct packed {
    logic receive_irq_enable;
    logic rx9;
    logic continuous_receive_enable;
    logic single_receive_enable;
    logic clock_source_select;
    logic serial_port_enable;
  } ssr_ctrl_t;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } ssr_entry_t;

  localparam ssr_ctrl_t CTRL_RESET = '0;

endpackage : ssr_pkg

// >>> hdl/ssr_sync_rx.sv
`timescale 1ns/1ps

module ssr_sync_rx (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // APB slave.
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  // Receive data pin.
  input  wire logic        i_rx_data,
  output logic             o_rx_data_out,
  output logic             o_rx_data_oe,
  // Transmit clock pin.
  input  wire logic        i_ck_in,
  output logic             o_ck_out,
  output logic             o_ck_oe,
  // Receive request.
  output logic             o_rx_irq
);

  ssr_pkg::ssr_ctrl_t  ctrl;
  ssr_pkg::ssr_entry_t mem [ssr_pkg::FIFO_DEPTH];
  logic [15:0] baud;
  logic [15:0] div_cnt;
  logic        ck_q;
  logic        dt_s1, dt_s2;
  logic        ck_s1, ck_s2, ck_s3;
  logic [8:0]  shreg;
  logic [3:0]  bit_cnt;
  logic        rd_ptr, wr_ptr;
  logic [1:0]  count;
  logic        ovr;
  logic        ovr_single;

  logic        access, take, complete;
  logic        wr_ctrl, rd_data;
  logic        master, run, tick, trail, last, char_done;
  logic        push, pop, continuous_receive_enable_drop;
  logic [8:0]  next_sh;
  ssr_pkg::ssr_entry_t next_entry;
  ssr_pkg::ssr_entry_t head;

  function automatic logic [31:0] read_mux(input logic [7:0] a,
                                           input ssr_pkg::ssr_ctrl_t c,
                                           input logic [15:0] b,
                                           input ssr_pkg::ssr_entry_t h,
                                           input logic [1:0] n,
                                           input logic o);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      ssr_pkg::ADDR_CTRL:   r[5:0] = c;
      ssr_pkg::ADDR_BAUD:   r[15:0] = b;
      ssr_pkg::ADDR_DATA:   r[7:0] = h.data;
      ssr_pkg::ADDR_STATUS: begin
        r[ssr_pkg::STAT_PEND]  = (n != 2'h0);
        r[ssr_pkg::STAT_OVR]   = o;
        r[ssr_pkg::STAT_NINTH] = h.ninth;
        r[ssr_pkg::STAT_CNT +: 2] = n;
      end
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a == ssr_pkg::ADDR_CTRL) || (a == ssr_pkg::ADDR_STATUS) ||
           (a == ssr_pkg::ADDR_DATA) || (a == ssr_pkg::ADDR_BAUD);
  endfunction

  // Bus decode. Every access takes one wait state so read data is
  // registered; writes and the pop act on the completing edge.
  assign access   = i_psel && i_penable;
  assign take     = access && !o_pready;
  assign complete = access && o_pready;
  assign wr_ctrl  = complete && i_pwrite &&
                    (i_paddr == ssr_pkg::ADDR_CTRL);
  assign rd_data  = complete && !i_pwrite &&
                    (i_paddr == ssr_pkg::ADDR_DATA);
  assign continuous_receive_enable_drop = wr_ctrl && ctrl.continuous_receive_enable &&
                     !i_pwdata[ssr_pkg::CTRL_CONTINUOUS_RECEIVE_ENABLE];

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= take;
      if (take) begin
        o_prdata  <= read_mux(i_paddr, ctrl, baud, head, count, ovr);
        o_pslverr <= !mapped(i_paddr);
      end
    end
  end

  // Software writes win over the hardware clear of single receive.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl <= ssr_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= ssr_pkg::ssr_ctrl_t'(i_pwdata[5:0]);
    end else if (char_done && ctrl.single_receive_enable) begin
      ctrl.single_receive_enable <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      baud <= ssr_pkg::BAUD_RESET;
    end else if (complete && i_pwrite &&
                 (i_paddr == ssr_pkg::ADDR_BAUD)) begin
      baud <= i_pwdata[15:0];
    end
  end

  // Pin synchronisers; the third clock stage feeds edge detection.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dt_s1 <= 1'b0;
      dt_s2 <= 1'b0;
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
    end else begin
      dt_s1 <= i_rx_data;
      dt_s2 <= dt_s1;
      ck_s1 <= i_ck_in;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
    end
  end

  assign master = ctrl.serial_port_enable && ctrl.clock_source_select;
  assign run    = ctrl.serial_port_enable && (ctrl.single_receive_enable || ctrl.continuous_receive_enable) && !ovr;
  // A divisor of zero behaves as one, so the clock never stalls on it.
  assign tick   = master && run &&
                  ((baud == 16'h0000) || (div_cnt >= baud - 16'h0001));

  // Master clock idles low; rising is leading, falling is trailing.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_cnt <= 16'h0000;
      ck_q    <= 1'b0;
    end else if (!(master && run) || continuous_receive_enable_drop) begin
      div_cnt <= 16'h0000;
      ck_q    <= 1'b0;
    end else if (tick) begin
      div_cnt <= 16'h0000;
      ck_q    <= !ck_q;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  assign trail = run && (master ? (tick && ck_q) : (!ck_s2 && ck_s3));
  // Eight or nine bits per character.
  assign last  = bit_cnt == ((ctrl.rx9 ? ssr_pkg::BITS_9 :
                              ssr_pkg::BITS_8) - 4'h1);
  assign char_done = trail && last && !continuous_receive_enable_drop;
  assign next_sh   = {dt_s2, shreg[8:1]};

  always_comb begin
    next_entry = '0;
    if (ctrl.rx9) begin
      next_entry = ssr_pkg::ssr_entry_t'(next_sh);
    end else begin
      next_entry.data = next_sh[8:1];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      shreg   <= 9'h000;
      bit_cnt <= 4'h0;
    end else if (!run || continuous_receive_enable_drop) begin
      bit_cnt <= 4'h0;
    end else if (trail) begin
      shreg   <= next_sh;
      bit_cnt <= last ? 4'h0 : bit_cnt + 4'h1;
    end
  end

  assign push = char_done && (count != ssr_pkg::CNT_FULL) && !ovr;
  // Data read pops the oldest entry.
  assign pop  = rd_data && (count != 2'h0);
  // Head entry feeds data and ninth bit.
  assign head = mem[rd_ptr];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= next_entry;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count  <= 2'h0;
    end else if (!ctrl.serial_port_enable) begin
      // Disabling the port flushes it.
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= !wr_ptr;
      end
      if (pop) begin
        rd_ptr <= !rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // Overrun flag has no write path; only conditions clear it.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ovr        <= 1'b0;
      ovr_single <= 1'b0;
    end else if (char_done && (count == ssr_pkg::CNT_FULL) && !ovr) begin
      ovr        <= 1'b1;
      ovr_single <= ctrl.single_receive_enable && !ctrl.continuous_receive_enable;
    end else if (!ctrl.serial_port_enable) begin
      ovr <= 1'b0;
    end else if (ovr_single && rd_data) begin
      ovr <= 1'b0;
    end else if (!ovr_single && !ctrl.continuous_receive_enable) begin
      ovr <= 1'b0;
    end
  end

  // Pin drivers and receive request, all registered.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ck_out      <= 1'b0;
      o_ck_oe       <= 1'b0;
      o_rx_data_out <= 1'b0;
      o_rx_data_oe  <= 1'b0;
      o_rx_irq      <= 1'b0;
    end else begin
      o_ck_out      <= ck_q;
      o_ck_oe       <= master;
      o_rx_data_out <= 1'b0;
      o_rx_data_oe  <= 1'b0;
      o_rx_irq      <= (count != 2'h0) && ctrl.receive_irq_enable;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_third_char;
    char_done && (count == ssr_pkg::CNT_FULL) && !ovr;
  endsequence

  sequence s_ovr_hold;
    ovr && (count == ssr_pkg::CNT_FULL) ##1 ovr;
  endsequence

  data_oe_off_a: assert property (
    !o_rx_data_oe) else $error("data pin driven during receive");

  single_receive_enable_clear_a: assert property (
    char_done && ctrl.single_receive_enable && !wr_ctrl |=> !ctrl.single_receive_enable)
    else $error("single receive not cleared");

  clock_toggle_a: assert property (
    tick && !continuous_receive_enable_drop |=> ck_q != $past(ck_q))
    else $error("master clock paused");

  continuous_receive_enable_abort_a: assert property (
    continuous_receive_enable_drop |=> (bit_cnt == 4'h0) && !ck_q)
    else $error("partial character kept");

  fifo_push_a: assert property (
    push && !pop && ctrl.serial_port_enable |=> count == $past(count) + 2'h1)
    else $error("character not stored");

  overrun_set_a: assert property (
    s_third_char |=> s_ovr_hold)
    else $error("overrun not flagged or data lost");

  ovr_block_a: assert property (
    ovr |=> count <= $past(count))
    else $error("character accepted in overrun");

  single_clear_a: assert property (
    ovr && ovr_single && rd_data && ctrl.serial_port_enable |=> !ovr)
    else $error("data read left overrun set");

  fifo_pop_a: assert property (
    pop && !push && ctrl.serial_port_enable |=> count == $past(count) - 2'h1)
    else $error("read did not pop");

  irq_follow_a: assert property (
    (count != 2'h0) && ctrl.receive_irq_enable |=> o_rx_irq)
    else $error("receive request missing");

endmodule // ssr_sync_rx

// >>> sim/ssr_serial_peer.sv
`timescale 1ns/1ps

module ssr_serial_peer (
  // Device clock pin.
  input  wire logic i_ck_dev,
  input  wire logic i_ck_oe,
  // Lines driven by the peer.
  output logic      o_ck,
  output logic      o_data
);
  logic      bits[$];
  wire logic lead;

  // Our own clock idles low, so it only leads while the device is slave.
  assign lead = i_ck_oe ? i_ck_dev : o_ck;

  initial begin
    o_ck   = 1'b0;
    o_data = 1'b0;
  end

  // Data on leading edge.
  // With nothing queued the line toggles, so a stale bit never looks valid.
  always @(posedge lead) begin
    if (bits.size() > 0) begin
      o_data <= bits.pop_front();
    end else begin
      o_data <= ~o_data;
    end
  end

  task automatic clock_out(input int n);
    #1.3;
    repeat (n) begin
      #32 o_ck = 1'b1;
      #32 o_ck = 1'b0;
    end
  endtask
endmodule // ssr_serial_peer

// >>> sim/sync_serial_receiver_test.sv
`timescale 1ns/1ps

module sync_serial_receiver_test;
  logic        i_clk, i_nrst, i_psel, i_penable, i_pwrite, i_rx_data;
  logic        i_ck_in, o_pready, o_pslverr, o_rx_data_out, o_rx_data_oe;
  logic        o_ck_out, o_ck_oe, o_rx_irq, serr, exp_ovr, n9;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [8:0]  exp_q[$];
  int          err_count, check_count, rises, seed, base, n;

  ssr_sync_rx dut (.*);
  ssr_serial_peer peer (.i_ck_dev(o_ck_out), .i_ck_oe(o_ck_oe),
                        .o_ck(i_ck_in), .o_data(i_rx_data));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge o_ck_out) rises++;

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    i_psel   <= 1'b1;
    i_pwrite <= w;
    i_paddr  <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    rd   = o_prdata;
    serr = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    if (k >= 20) begin
      err_count++;
      give_verdict();
    end
  endtask

  // Ninth bit is only compared while nine-bit data is being received.
  task automatic st_chk();
    logic [31:0] m;
    logic [1:0]  c;
    c = 2'(exp_q.size());
    m = (c == 2'h0 || !n9) ? 32'hFFFF_FFFB : 32'hFFFF_FFFF;
    apb(1'b0, ssr_pkg::ADDR_STATUS, 32'h0);
    chk("status", m & {26'h0, c, 1'b0, exp_q[0][8], exp_ovr, c != 2'h0},
        m & rd);
  endtask

  task automatic pop_chk();
    apb(1'b0, ssr_pkg::ADDR_DATA, 32'h0);
    chk("data", {24'h0, exp_q[0][7:0]}, rd);
    void'(exp_q.pop_front());
  endtask

  task automatic send(input int nb);
    logic [8:0] ch;
    ch = 9'($random(seed));
    for (int i = 0; i < nb; i++) peer.bits.push_back(ch[i]);
    if (nb == 8) ch[8] = 1'b0;
    if (exp_ovr || exp_q.size() == 2) exp_ovr = 1'b1;
    else exp_q.push_back(ch);
  endtask

  task automatic wait_st(input logic [31:0] m, v);
    int k;
    k = 0;
    do begin
      apb(1'b0, ssr_pkg::ADDR_STATUS, 32'h0);
      k++;
    end while ((rd & m) !== v && k < 400);
    if (k >= 400) begin
      err_count++;
      give_verdict();
    end
  endtask

  initial begin
    seed = 32'hC9EB;
    {err_count, check_count, rises, exp_ovr, n9} = '0;
    {i_nrst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    apb(1'b0, ssr_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, ssr_pkg::ADDR_BAUD, 32'h0);
    chk("baud reset", {16'h0, ssr_pkg::BAUD_RESET}, rd);
    apb(1'b1, 8'h10, 32'h5);
    chk("unmapped error", 32'h1, {31'h0, serr});
    apb(1'b1, ssr_pkg::ADDR_BAUD, 32'h8);
    $display("Test reset and map done");
    send(8);
    base = rises;
    apb(1'b1, ssr_pkg::ADDR_CTRL, 32'h03);
    apb(1'b1, ssr_pkg::ADDR_CTRL, 32'h07);
    wait_st(32'h30, 32'h10);
    repeat (40) @(posedge i_clk);
    chk("single clocks", 32'h8, 32'(rises - base));
    apb(1'b0, ssr_pkg::ADDR_CTRL, 32'h0);
    chk("single cleared", 32'h03, rd);
    chk("data oe", 32'h0, {31'h0, o_rx_data_oe});
    chk("data out", 32'h0, {31'h0, o_rx_data_out});
    chk("master clock oe", 32'h1, {31'h0, o_ck_oe});
    st_chk();
    pop_chk();
    st_chk();
    $display("Test single receive done");
    repeat (3) send(8);
    apb(1'b1, ssr_pkg::ADDR_CTRL, 32'h2B);
    wait_st(32'h02, 32'h02);
    st_chk();
    chk("irq", 32'h1, {31'h0, o_rx_irq});
    pop_chk();
    st_chk();
    pop_chk();
    apb(1'b1, ssr_pkg::ADDR_CTRL, 32'h23);
    exp_ovr = 1'b0;
    st_chk();
    $display("Test continuous overrun done");
    n9 = 1'b1;
    repeat (2) send(9);
    apb(1'b1, ssr_pkg::ADDR_CTRL, 32'h1F);
    wait_st(32'h30, 32'h20);
    apb(1'b0, ssr_pkg::ADDR_CTRL, 32'h0);
    chk("both enables", 32'h1B, rd);
    apb(1'b1, ssr_pkg::ADDR_CTRL, 32'h13);
    exp_ovr = 1'b0;
    st_chk();
    pop_chk();
    st_chk();
    pop_chk();
    n9 = 1'b0;
    $display("Test nine bit done");
    peer.bits.delete();
    base = rises;
    apb(1'b1, ssr_pkg::ADDR_CTRL, 32'h0B);
    for (n = 0; n < 200 && rises < base + 4; n++) @(posedge i_clk);
    if (rises < base + 4) begin
      err_count++;
      give_verdict();
    end
    apb(1'b1, ssr_pkg::ADDR_CTRL, 32'h03);
    repeat (2) @(posedge i_clk);
    base = rises;
    repeat (40) @(posedge i_clk);
    chk("abort clocks", 32'h0, 32'(rises - base));
    st_chk();
    $display("Test abort done");
    for (int k = 0; k < 3; k++) begin
      send(8);
      apb(1'b1, ssr_pkg::ADDR_CTRL, 32'h05);
      peer.clock_out(8);
      repeat (8) @(posedge i_clk);
    end
    chk("clock oe", 32'h0, {31'h0, o_ck_oe});
    apb(1'b1, ssr_pkg::ADDR_STATUS, 32'h0);
    st_chk();
    pop_chk();
    exp_ovr = 1'b0;
    st_chk();
    apb(1'b1, ssr_pkg::ADDR_CTRL, 32'h0);
    exp_q.delete();
    st_chk();
    $display("Test slave overrun done");
    give_verdict();
  end
endmodule // sync_serial_receiver_test
